// ### iov_pkg.sv
// Package: command codes, field layout, reset values and timing of the input over-voltage supervisor
package iov_pkg;

	// ==========================================================================
	// Command codes
	localparam logic [7:0] CMD_OV_FAULT_THR = 8'h55;
	localparam logic [7:0] CMD_OV_FAULT_ACT = 8'h56;
	localparam logic [7:0] CMD_OV_WARN_THR = 8'h57;
	localparam logic [7:0] CMD_UV_WARN_THR = 8'h58;

	// ==========================================================================
	// Fault action byte layout
	localparam int ACT_MODE_MSB = 7;
	localparam int ACT_MODE_LSB = 6;
	localparam int ACT_RETRY_MSB = 5;
	localparam int ACT_RETRY_LSB = 3;
	localparam int ACT_TIME_MSB = 2;
	localparam int ACT_TIME_LSB = 0;

	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_DELAY_RETRY = 2'h1;
	localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
	localparam logic [1:0] MODE_DISABLE_CLEAR = 2'h3;

	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ==========================================================================
	// Values after reset
	localparam logic [15:0] OV_FAULT_THR_RST = 16'h7fff;
	localparam logic [7:0] OV_FAULT_ACT_RST = 8'hc0;
	localparam logic [15:0] OV_WARN_THR_RST = 16'h7fff;
	localparam logic [15:0] UV_WARN_THR_RST = 16'h0000;

	// ==========================================================================
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int DELAY_UNIT_MS = 10;
	localparam real RETRY_UNIT_MS = 8.2;
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * 1000 * CLK_MHZ;
	localparam int RETRY_UNIT_CYCLES = int'(RETRY_UNIT_MS * 1000.0 * CLK_MHZ);
	localparam int TMR_W = 27;

	// ==========================================================================
	// Supervisor states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_DELAY,
		ST_OFF_WAIT,
		ST_HOLD,
		ST_LATCHED
	} iov_state_t;

endpackage : iov_pkg

// ### iov_link_port.sv
// Link-clock side of the command port with toggle handshake into the core clock
`timescale 1ns/1ps
module iov_link_port (
	input wire logic link_clk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	output logic rsp_err_o,
	output logic req_tgl_o,
	output logic hold_write_o,
	output logic [7:0] hold_code_o,
	output logic [15:0] hold_wdata_o,
	input wire logic ack_tgl_i,
	input wire logic [15:0] core_rdata_i,
	input wire logic core_err_i
);

	// ==========================================================================
	// Reset brought into the link domain
	logic rst_meta_q;
	logic rst_q;
	always_ff @(posedge link_clk_i) begin
		rst_meta_q <= sys_rst_i;
		rst_q <= rst_meta_q;
	end

	// ==========================================================================
	// Acknowledge synchroniser
	logic ack_meta_q;
	logic ack_sync_q;
	logic ack_seen_q;
	always_ff @(posedge link_clk_i) begin
		ack_meta_q <= ack_tgl_i;
		ack_sync_q <= ack_meta_q;
	end

	// ==========================================================================
	// Request capture; the held fields stay still until the core answers
	always_ff @(posedge link_clk_i) begin
		if (rst_q) begin
			cmd_ready_o <= 1'b1;
			req_tgl_o <= 1'b0;
			hold_write_o <= 1'b0;
			hold_code_o <= 8'h00;
			hold_wdata_o <= 16'h0000;
			ack_seen_q <= 1'b0;
		end else begin
			ack_seen_q <= ack_sync_q;
			if (cmd_valid_i && cmd_ready_o) begin
				cmd_ready_o <= 1'b0;
				req_tgl_o <= ~req_tgl_o;
				hold_write_o <= cmd_write_i;
				hold_code_o <= cmd_code_i;
				hold_wdata_o <= cmd_wdata_i;
			end else if (ack_sync_q != ack_seen_q) begin
				cmd_ready_o <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Answer; core data are stable once the acknowledge toggle arrives
	always_ff @(posedge link_clk_i) begin
		if (rst_q) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 16'h0000;
			rsp_err_o <= 1'b0;
		end else begin
			rsp_valid_o <= ack_sync_q != ack_seen_q;
			if (ack_sync_q != ack_seen_q) begin
				rsp_data_o <= core_rdata_i;
				rsp_err_o <= core_err_i;
			end
		end
	end

endmodule : iov_link_port

// ### iov_supervisor.sv
// Input over-voltage supervisor: limit registers, comparators, fault response sequencer
//
// Operation
// - Fault threshold word at code 0x55, read/write
// - Fault action byte at code 0x56, read/write
// - Mode 00 keeps regulating through fault
// - Any mode: alert low, fault flag set
// - Mode 01: run for delay, then retry
// - Mode 10: disable at once, then retry
// - Mode 11: off while fault, auto resume
// - Bits 5:3 codes 1-6 give attempts
// - Code 000: no retry, off until cleared
// - All attempts failed: off until cleared
// - Code 111 retries until off or fault
// - Retry spacing is bits 2:0 times unit
// - Operate delay counts in 10 ms units
// - Retry interval counts in 8.2 ms units
// - Over-voltage warning word at code 0x57
// - Under-voltage warning word at code 0x58
`timescale 1ns/1ps
module iov_supervisor import iov_pkg::*; #(
	parameter int DELAY_UNIT_CYC = DELAY_UNIT_CYCLES,
	parameter int RETRY_UNIT_CYC = RETRY_UNIT_CYCLES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	output logic rsp_err_o,
	input wire logic [15:0] vin_meas_i,
	input wire logic output_cmd_i,
	input wire logic other_fault_i,
	input wire logic fault_clear_i,
	output logic output_en_o,
	output logic alert_output_n_o,
	output logic ov_fault_flag_o,
	output logic ov_warn_flag_o,
	output logic uv_warn_flag_o,
	output logic [2:0] restart_count_o
);

	// ==========================================================================
	// Helpers

	// Linear word to signed fixed point with 16 fraction bits, so that
	// values with different exponents compare correctly
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
		logic [5:0] sh;
		sh = {w[15], w[15:11]} + 6'd16;
		return {{37{w[10]}}, w[10:0]} <<< sh;
	endfunction : lin_to_fix

	function automatic logic [TMR_W-1:0] tmr_load(input logic [2:0] mult, input int unit_cyc);
		return TMR_W'(mult) * TMR_W'(unit_cyc);
	endfunction : tmr_load

	// ==========================================================================
	// Link-side port
	logic req_tgl;
	logic hold_write;
	logic [7:0] hold_code;
	logic [15:0] hold_wdata;
	logic ack_tgl_q;
	logic [15:0] rd_data_q;
	logic rd_err_q;

	iov_link_port u_link (
		.link_clk_i(link_clk_i),
		.sys_rst_i(sys_rst_i),
		.cmd_valid_i(cmd_valid_i),
		.cmd_write_i(cmd_write_i),
		.cmd_code_i(cmd_code_i),
		.cmd_wdata_i(cmd_wdata_i),
		.cmd_ready_o(cmd_ready_o),
		.rsp_valid_o(rsp_valid_o),
		.rsp_data_o(rsp_data_o),
		.rsp_err_o(rsp_err_o),
		.req_tgl_o(req_tgl),
		.hold_write_o(hold_write),
		.hold_code_o(hold_code),
		.hold_wdata_o(hold_wdata),
		.ack_tgl_i(ack_tgl_q),
		.core_rdata_i(rd_data_q),
		.core_err_i(rd_err_q)
	);

	// ==========================================================================
	// Request toggle synchroniser
	logic req_meta_q;
	logic req_sync_q;
	logic req_seen_q;
	logic new_req;

	always_ff @(posedge clk_i) begin
		req_meta_q <= req_tgl;
		req_sync_q <= req_meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			req_seen_q <= 1'b0;
		end else begin
			req_seen_q <= req_sync_q;
		end
	end

	assign new_req = req_sync_q != req_seen_q;

	// ==========================================================================
	// Limit and action registers
	logic [15:0] ov_fault_thr_q;
	logic [7:0] ov_fault_act_q;
	logic [15:0] ov_warn_thr_q;
	logic [15:0] uv_warn_thr_q;
	logic wr;

	assign wr = new_req && hold_write;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ov_fault_thr_q <= OV_FAULT_THR_RST;
			ov_fault_act_q <= OV_FAULT_ACT_RST;
			ov_warn_thr_q <= OV_WARN_THR_RST;
			uv_warn_thr_q <= UV_WARN_THR_RST;
		end else if (wr) begin
			unique case (hold_code)
				CMD_OV_FAULT_THR: ov_fault_thr_q <= hold_wdata;
				CMD_OV_FAULT_ACT: ov_fault_act_q <= hold_wdata[7:0];
				CMD_OV_WARN_THR: ov_warn_thr_q <= hold_wdata;
				CMD_UV_WARN_THR: uv_warn_thr_q <= hold_wdata;
				default: ;
			endcase
		end
	end

	// Read answer; unknown codes answer zero with the error bit set
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_q <= 16'h0000;
			rd_err_q <= 1'b0;
			ack_tgl_q <= 1'b0;
		end else if (new_req) begin
			ack_tgl_q <= ~ack_tgl_q;
			rd_err_q <= 1'b0;
			unique case (hold_code)
				CMD_OV_FAULT_THR: rd_data_q <= ov_fault_thr_q;
				CMD_OV_FAULT_ACT: rd_data_q <= {8'h00, ov_fault_act_q};
				CMD_OV_WARN_THR: rd_data_q <= ov_warn_thr_q;
				CMD_UV_WARN_THR: rd_data_q <= uv_warn_thr_q;
				default: begin
					rd_data_q <= 16'h0000;
					rd_err_q <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================================
	// Comparators and sticky flags
	logic ov_fault;
	logic ov_warn;
	logic uv_warn;
	logic ov_fault_flag_d;
	logic ov_warn_flag_d;
	logic uv_warn_flag_d;

	assign ov_fault = lin_to_fix(vin_meas_i) > lin_to_fix(ov_fault_thr_q);
	assign ov_warn = lin_to_fix(vin_meas_i) > lin_to_fix(ov_warn_thr_q);
	assign uv_warn = lin_to_fix(vin_meas_i) < lin_to_fix(uv_warn_thr_q);

	// A condition present in the clearing cycle keeps its flag set
	assign ov_fault_flag_d = (ov_fault_flag_o && !fault_clear_i) || ov_fault;
	assign ov_warn_flag_d = (ov_warn_flag_o && !fault_clear_i) || ov_warn;
	assign uv_warn_flag_d = (uv_warn_flag_o && !fault_clear_i) || uv_warn;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ov_fault_flag_o <= 1'b0;
			ov_warn_flag_o <= 1'b0;
			uv_warn_flag_o <= 1'b0;
			alert_output_n_o <= 1'b1;
		end else begin
			ov_fault_flag_o <= ov_fault_flag_d;
			ov_warn_flag_o <= ov_warn_flag_d;
			uv_warn_flag_o <= uv_warn_flag_d;
			alert_output_n_o <= !(ov_fault_flag_d || ov_warn_flag_d || uv_warn_flag_d);
		end
	end

	// ==========================================================================
	// Fault response sequencer
	iov_state_t state_q;
	iov_state_t state_d;
	logic [2:0] tries_q;
	logic [2:0] tries_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic [1:0] mode;
	logic [2:0] retry_code;
	logic [2:0] time_mult;
	logic tmr_done;
	logic abort;

	assign mode = ov_fault_act_q[ACT_MODE_MSB:ACT_MODE_LSB];
	assign retry_code = ov_fault_act_q[ACT_RETRY_MSB:ACT_RETRY_LSB];
	assign time_mult = ov_fault_act_q[ACT_TIME_MSB:ACT_TIME_LSB];
	assign tmr_done = tmr_q == '0;
	// Retrying stops when the output is commanded off or another fault trips
	assign abort = !output_cmd_i || other_fault_i;

	always_comb begin
		state_d = state_q;
		tries_d = tries_q;
		tmr_d = tmr_done ? tmr_q : tmr_q - TMR_W'(1);
		unique case (state_q)
			ST_RUN: begin
				if (ov_fault) begin
					unique case (mode)
						MODE_IGNORE: state_d = ST_RUN;
						MODE_DELAY_RETRY: begin
							state_d = ST_DELAY;
							tmr_d = tmr_load(time_mult, DELAY_UNIT_CYC);
						end
						MODE_DISABLE_RETRY: begin
							state_d = (retry_code == RETRY_NONE) ? ST_LATCHED : ST_OFF_WAIT;
							tmr_d = tmr_load(time_mult, RETRY_UNIT_CYC);
						end
						MODE_DISABLE_CLEAR: state_d = ST_HOLD;
					endcase
				end
			end
			ST_DELAY: begin
				if (!ov_fault) begin
					state_d = ST_RUN;
				end else if (tmr_done) begin
					state_d = (retry_code == RETRY_NONE) ? ST_LATCHED : ST_OFF_WAIT;
					tmr_d = tmr_load(time_mult, RETRY_UNIT_CYC);
				end
			end
			ST_OFF_WAIT: begin
				if (abort) begin
					state_d = ST_LATCHED;
				end else if (tmr_done) begin
					if (!ov_fault) begin
						state_d = ST_RUN;
						tries_d = 3'h0;
					end else if (retry_code == RETRY_FOREVER) begin
						tmr_d = tmr_load(time_mult, RETRY_UNIT_CYC);
					end else if (tries_q + 3'h1 >= retry_code) begin
						state_d = ST_LATCHED;
						tries_d = tries_q + 3'h1;
					end else begin
						tries_d = tries_q + 3'h1;
						tmr_d = tmr_load(time_mult, RETRY_UNIT_CYC);
					end
				end
			end
			ST_HOLD: begin
				if (!ov_fault) begin
					state_d = ST_RUN;
				end
			end
			ST_LATCHED: begin
				if (fault_clear_i && !ov_fault) begin
					state_d = ST_RUN;
					tries_d = 3'h0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_RUN;
			tries_q <= 3'h0;
			tmr_q <= '0;
		end else begin
			state_q <= state_d;
			tries_q <= tries_d;
			tmr_q <= tmr_d;
		end
	end

	// Output stays on only while running or riding out the operate delay
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			output_en_o <= 1'b0;
			restart_count_o <= 3'h0;
		end else begin
			output_en_o <= output_cmd_i && (state_d == ST_RUN || state_d == ST_DELAY);
			restart_count_o <= tries_d;
		end
	end

endmodule : iov_supervisor

// ### iov_supervisor_monitor.sv
// Checker: port assertions of the input over-voltage supervisor
`timescale 1ns/1ps
module iov_supervisor_monitor #(
	parameter int DELAY_UNIT_CYC = 10,
	parameter int RETRY_UNIT_CYC = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [15:0] rsp_data_o,
	input wire logic rsp_err_o,
	input wire logic output_cmd_i,
	input wire logic fault_clear_i,
	input wire logic output_en_o,
	input wire logic alert_output_n_o,
	input wire logic ov_fault_flag_o,
	input wire logic ov_warn_flag_o,
	input wire logic uv_warn_flag_o,
	input wire logic [2:0] restart_count_o
);
	// ======
	// Command port
	// Two synchronisers each way plus slack
	localparam int RSP_MAX = 24;
	sequence s_take;
		cmd_valid_i && cmd_ready_o;
	endsequence
	sequence s_answer;
		!cmd_ready_o ##[1:RSP_MAX] rsp_valid_o;
	endsequence
	chk_answer_due: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		s_take |=> s_answer) else $error("no answer in time");
	chk_pulse_once: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		rsp_valid_o |=> !rsp_valid_o) else $error("answer pulse too long");
	chk_err_zero: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		rsp_valid_o && rsp_err_o |-> rsp_data_o == 16'h0000) else $error("error data not 0");
	// ======
	// Supervisor
	chk_alert_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		alert_output_n_o == !(ov_fault_flag_o || ov_warn_flag_o || uv_warn_flag_o))
		else $error("alert differs from flags");
	chk_cmd_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!output_cmd_i |=> !output_en_o) else $error("on while commanded off");
	chk_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(ov_fault_flag_o) |-> $past(fault_clear_i)) else $error("flag lost");
	chk_count_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(restart_count_o) |-> restart_count_o == 3'h0
		|| restart_count_o == $past(restart_count_o) + 3'h1) else $error("count jump");
	chk_fail_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$changed(restart_count_o) && restart_count_o != 3'h0 |-> !output_en_o)
		else $error("on after failed attempt");
endmodule : iov_supervisor_monitor

bind iov_supervisor iov_supervisor_monitor #(
	.DELAY_UNIT_CYC(DELAY_UNIT_CYC), .RETRY_UNIT_CYC(RETRY_UNIT_CYC)
) u_mon (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
	.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
	.rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .output_cmd_i(output_cmd_i),
	.fault_clear_i(fault_clear_i), .output_en_o(output_en_o),
	.alert_output_n_o(alert_output_n_o), .ov_fault_flag_o(ov_fault_flag_o),
	.ov_warn_flag_o(ov_warn_flag_o), .uv_warn_flag_o(uv_warn_flag_o),
	.restart_count_o(restart_count_o)
);

// ### iov_host_model.sv
// Host model: issues one command at a time on the link-clock port
`timescale 1ns/1ps
module iov_host_model (
	input wire logic link_clk_i,
	output logic cmd_valid_o,
	output logic cmd_write_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_wdata_o,
	input wire logic cmd_ready_i,
	input wire logic rsp_valid_i,
	input wire logic [15:0] rsp_data_i,
	input wire logic rsp_err_i
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd, output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge link_clk_i);
		#1;
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_code_o = code;
		cmd_wdata_o = wd;
		do begin
			@(posedge link_clk_i);
			n++;
		end while (cmd_ready_i !== 1'b1 && n < 40);
		#1;
		cmd_valid_o = 1'b0;
		// Released lines carry the inverse so stale values never look valid
		cmd_write_o = ~wr;
		cmd_code_o = ~code;
		cmd_wdata_o = ~wd;
		do begin
			@(posedge link_clk_i);
			n++;
		end while (rsp_valid_i !== 1'b1 && n < 80);
		rd = rsp_data_i;
		err = rsp_err_i;
		ok = (rsp_valid_i === 1'b1);
	endtask : xfer
endmodule : iov_host_model

// ### testbench.sv
// Testbench: register access and fault response scenarios
`timescale 1ns/1ps
module testbench;
	import iov_pkg::*;
	localparam int RCYC = 8;
	localparam logic [15:0] V_OK = 16'h0040;
	localparam logic [15:0] V_OV = 16'h0070;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cv, cw, crdy, rv, rerr, out_en, aln, ovf, ovw, uvw;
	logic [7:0] cc;
	logic [7:0] cur = 8'hcd;
	logic [15:0] cd, rd;
	logic [15:0] vin = 16'h7c00;
	logic ocmd = 1'b1;
	logic oth = 1'b0;
	logic clr = 1'b0;
	logic [2:0] rcnt;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	initial forever #5 clk_i = ~clk_i;
	initial begin
		#3;
		forever #6 link_clk_i = ~link_clk_i;
	end
	iov_supervisor #(.DELAY_UNIT_CYC(10), .RETRY_UNIT_CYC(RCYC)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .cmd_valid_i(cv),
		.cmd_write_i(cw), .cmd_code_i(cc), .cmd_wdata_i(cd), .cmd_ready_o(crdy),
		.rsp_valid_o(rv), .rsp_data_o(rd), .rsp_err_o(rerr), .vin_meas_i(vin),
		.output_cmd_i(ocmd), .other_fault_i(oth), .fault_clear_i(clr), .output_en_o(out_en),
		.alert_output_n_o(aln), .ov_fault_flag_o(ovf), .ov_warn_flag_o(ovw),
		.uv_warn_flag_o(uvw), .restart_count_o(rcnt));
	iov_host_model host (.link_clk_i(link_clk_i), .cmd_valid_o(cv), .cmd_write_o(cw),
		.cmd_code_o(cc), .cmd_wdata_o(cd), .cmd_ready_i(crdy), .rsp_valid_i(rv),
		.rsp_data_i(rd), .rsp_err_i(rerr));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Order: fault, over warn, under warn, alert_n, enable
	task automatic st(input logic [4:0] e);
		chk({11'h0, ovf, ovw, uvw, aln, out_en}, {11'h0, e});
	endtask : st
	task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic [15:0] e, input logic bad);
		logic [15:0] r;
		logic err, ok;
		host.xfer(w, c, d, r, err, ok);
		chk({14'h0, ok, err}, {14'h0, 1'b1, bad});
		chk(r, e);
	endtask : acc
	task automatic set_act(input logic [7:0] v);
		vin = V_OK;
		acc(1'b1, CMD_OV_FAULT_ACT, {8'h00, v}, {8'h00, cur}, 1'b0);
		cur = v;
		tick(1);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(2);
		st(5'b00011);
		chk({13'h0, rcnt}, 16'h0000);
	endtask : set_act
	task automatic t_regs;
		logic [7:0] c [4] = '{CMD_OV_FAULT_THR, CMD_OV_FAULT_ACT, CMD_OV_WARN_THR,
			CMD_UV_WARN_THR};
		logic [15:0] r [4] = '{OV_FAULT_THR_RST, {8'h00, OV_FAULT_ACT_RST}, OV_WARN_THR_RST,
			UV_WARN_THR_RST};
		logic [15:0] w [4] = '{16'h0064, 16'habcd, 16'h0050, 16'h0020};
		logic [15:0] b [4] = '{16'h0064, 16'h00cd, 16'h0050, 16'h0020};
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, c[i], 16'h0000, r[i], 1'b0);
			acc(1'b1, c[i], w[i], r[i], 1'b0);
			acc(1'b0, c[i], 16'h0000, b[i], 1'b0);
		end
		acc(1'b1, 8'h59, 16'h1234, 16'h0000, 1'b1);
	endtask : t_regs
	task automatic t_ignore;
		set_act(8'h00);
		vin = 16'h0060;
		tick(3);
		st(5'b01001);
		vin = V_OV;
		repeat (30) begin
			tick(1);
			chk({15'h0, out_en}, 16'h0001);
		end
		st(5'b11001);
	endtask : t_ignore
	task automatic t_delay;
		set_act(8'h42);
		vin = V_OV;
		tick(5);
		vin = V_OK;
		tick(25);
		chk({15'h0, out_en}, 16'h0001);
		vin = V_OV;
		tick(18);
		st(5'b11001);
		tick(8);
		st(5'b11000);
		vin = V_OK;
		tick(30);
		st(5'b11000);
	endtask : t_delay
	task automatic t_retry;
		int n;
		set_act(8'h92);
		vin = V_OV;
		tick(2);
		st(5'b11000);
		for (int k = 1; k < 3; k++) begin
			n = 0;
			while (rcnt !== k[2:0] && n < 200) begin
				tick(1);
				n++;
			end
			chk({15'h0, n >= 2 * RCYC && n <= 2 * RCYC + 4}, 16'h0001);
		end
		vin = V_OK;
		tick(60);
		st(5'b11000);
		chk({13'h0, rcnt}, 16'h0002);
		set_act(8'h89);
		vin = V_OV;
		tick(3);
		vin = V_OK;
		tick(RCYC + 4);
		st(5'b11001);
		chk({13'h0, rcnt}, 16'h0000);
	endtask : t_retry
	task automatic t_forever;
		set_act(8'hb9);
		vin = V_OV;
		tick(100);
		chk({15'h0, out_en}, 16'h0000);
		vin = V_OK;
		tick(RCYC + 4);
		chk({15'h0, out_en}, 16'h0001);
		vin = V_OV;
		tick(3);
		oth = 1'b1;
		tick(2);
		oth = 1'b0;
		vin = V_OK;
		tick(30);
		chk({15'h0, out_en}, 16'h0000);
	endtask : t_forever
	task automatic t_hold;
		set_act(8'hc0);
		vin = 16'h0060;
		tick(3);
		st(5'b01001);
		vin = V_OV;
		tick(30);
		st(5'b11000);
		vin = V_OK;
		tick(3);
		st(5'b11001);
		ocmd = 1'b0;
		tick(3);
		chk({15'h0, out_en}, 16'h0000);
		ocmd = 1'b1;
	endtask : t_hold
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		tick(12);
		sys_rst_i = 1'b0;
		tick(12);
		st(5'b00101);
		t_regs();
		t_ignore();
		t_delay();
		t_retry();
		t_forever();
		t_hold();
		report_and_stop();
	end
endmodule : testbench
